// ===== rtl/adc_seq_pkg.sv
package adc_seq_pkg;
   localparam int CYCLES_PER_CONV = 16;   // serial clocks per conversion
   localparam int TRACK_CYCLES    = 3;    // track phase length
   localparam int CTRL_BITS       = 8;    // control byte width
   localparam int RESULT_BITS     = 10;   // result width
   localparam int CHAN_HI_POS     = 4;    // channel select high bit
   localparam int CHAN_LO_POS     = 3;    // channel select low bit
   localparam int MSB_FALL_EDGE   = 4;    // msb driven after this fall
   localparam logic [1:0] CHAN_RESET = 2'h0; // analog input one
   localparam logic [RESULT_BITS-1:0] SAMPLE_RESET = 10'h000;
endpackage : adc_seq_pkg

// ===== rtl/adc_link_if.sv
`timescale 1ns/1ps
// carries a sample request and its data into the system domain
interface adc_link_if;
   logic       sample_toggle;  // flips once per sample taken
   logic [1:0] sample_chan;    // channel held with the toggle
   modport link (output sample_toggle, output sample_chan);
   modport sys  (input  sample_toggle, input  sample_chan);
endinterface : adc_link_if

// ===== rtl/adc_sample_sync.sv
`timescale 1ns/1ps
// receives link-domain sample events and reports them in SYS_CLK domain
module adc_sample_sync (
   input  wire logic  clk,
   input  wire logic  rst_n,
   adc_link_if.sys    lnk,
   output logic       sample_pulse,
   output logic [1:0] sample_chan
);
   logic       sync_a;       // first stage, read only by sync_b
   logic       sync_b;       // second stage
   logic       sync_c;       // delayed copy for edge detect
   logic       next_pulse;   // toggle edge seen
   logic [1:0] next_chan;    // channel captured with the edge

   // detect a toggle change after synchronising
   always_comb begin
      next_pulse = sync_b ^ sync_c;
      next_chan  = next_pulse ? lnk.sample_chan : sample_chan;
   end

   // register stages; channel is stable long before the toggle arrives
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         sync_a       <= 1'b0;
         sync_b       <= 1'b0;
         sync_c       <= 1'b0;
         sample_pulse <= 1'b0;
         sample_chan  <= adc_seq_pkg::CHAN_RESET;
      end else begin
         sync_a       <= lnk.sample_toggle;
         sync_b       <= sync_a;
         sync_c       <= sync_b;
         sample_pulse <= next_pulse;
         sample_chan  <= next_chan;
      end
   end
endmodule : adc_sample_sync

// ===== rtl/adc_frame_seq.sv
`timescale 1ns/1ps
// frame sequencer and serial port of a four-input converter
module adc_frame_seq (
   input  wire logic                          SYS_CLK,
   input  wire logic                          RESETN,
   input  wire logic                          SCLK,
   input  wire logic                          CS_N,
   input  wire logic                          DIN,
   input  wire logic [adc_seq_pkg::RESULT_BITS-1:0] SAMPLE_CODE,
   output logic                               DOUT,
   output logic                               DOUT_OE_N,
   output logic                               TRACK,
   output logic [1:0]                         MUX_SEL,
   output logic                               POWER_UP,
   output logic                               SAMPLE_STROBE,
   output logic [1:0]                         SAMPLE_CHAN
);
   localparam int CW = 4;                     // cycle counter width
   typedef enum logic [1:0] {IDLE, TRACKING, CONVERTING} phase_t;

   // elaboration check on the cycle count this counter serves
   if (adc_seq_pkg::CYCLES_PER_CONV != 16) begin : g_chk
      $error("cycle count must be sixteen");
   end

   // link domain: chip select high is the asynchronous reset of all but chan and tog
   wire logic  lrst_n;                        // link reset, low while idle
   logic [CW-1:0] fall_cnt, next_fall_cnt;    // falling edges seen in group after the first
   logic [CW-1:0] rise_cnt, next_rise_cnt;    // rising edges seen in group
   logic [adc_seq_pkg::CTRL_BITS-1:0] ctrl, next_ctrl; // shifted-in byte
   logic [1:0] chan, next_chan;               // stored channel address
   logic [1:0] conv_chan, next_conv_chan;     // channel of this conversion
   logic [adc_seq_pkg::RESULT_BITS-1:0] shreg, next_shreg; // result shifter
   logic       dbit, next_dbit;               // serial output bit
   logic       oe, next_oe;                   // drives output while framed
   phase_t     phase, next_phase;             // conversion phase
   logic       tog, next_tog;                 // sample event toggle
   logic       started, next_started;         // first fall of frame seen

   assign lrst_n = RESETN & ~CS_N;

   adc_link_if lnk ();
   assign lnk.sample_toggle = tog;
   assign lnk.sample_chan   = conv_chan;

   // rising edges: capture control bits on first eight rises
   always_comb begin
      next_rise_cnt = (rise_cnt == CW'(adc_seq_pkg::CYCLES_PER_CONV-1))
                      ? '0 : rise_cnt + 1'b1;
      next_ctrl = ctrl;
      next_chan = chan;
      if (rise_cnt < CW'(adc_seq_pkg::CTRL_BITS))
         next_ctrl = {ctrl[adc_seq_pkg::CTRL_BITS-2:0], DIN};
      if (rise_cnt == CW'(adc_seq_pkg::CTRL_BITS-1))
         // only bits four and three matter
         next_chan = {ctrl[adc_seq_pkg::CHAN_HI_POS-1],
                      ctrl[adc_seq_pkg::CHAN_LO_POS-1]};
   end

   // rising-edge registers; channel survives frames, reset gives input one
   always_ff @(posedge SCLK or negedge RESETN) begin
      if (!RESETN) begin
         chan <= adc_seq_pkg::CHAN_RESET;
      end else begin
         chan <= (CS_N) ? chan : next_chan;
      end
   end

   // rising counters and byte clear with the frame
   always_ff @(posedge SCLK or negedge lrst_n) begin
      if (!lrst_n) begin
         rise_cnt <= '0;
         ctrl     <= '0;
      end else begin
         rise_cnt <= next_rise_cnt;
         ctrl     <= next_ctrl;
      end
   end

   // falling edges: phase, sample point and output shifting
   always_comb begin
      next_started   = 1'b1;
      next_fall_cnt  = started ? fall_cnt + 1'b1 : fall_cnt;
      next_phase     = phase;
      next_conv_chan = conv_chan;
      next_tog       = tog;
      next_shreg     = shreg;
      next_dbit      = dbit;
      next_oe        = 1'b1;                  // active while framed
      if (!started || fall_cnt == CW'(adc_seq_pkg::CYCLES_PER_CONV-1)) begin
         // first fall of a group: re-enter track
         next_fall_cnt  = '0;
         next_phase     = TRACKING;
         next_conv_chan = chan;
         next_dbit      = 1'b0;               // leading zero
      end else if (fall_cnt == CW'(adc_seq_pkg::TRACK_CYCLES-1)) begin
         // fourth fall: sample taken, hold and convert
         next_phase = CONVERTING;
         next_tog   = ~tog;
         next_dbit  = 1'b0;
      end else if (fall_cnt == CW'(adc_seq_pkg::MSB_FALL_EDGE-1)) begin
         // fifth clock: msb out
         next_shreg = {SAMPLE_CODE[adc_seq_pkg::RESULT_BITS-2:0], 1'b0};
         next_dbit  = SAMPLE_CODE[adc_seq_pkg::RESULT_BITS-1];
      end else if (phase == CONVERTING) begin
         next_dbit  = shreg[adc_seq_pkg::RESULT_BITS-1];
         next_shreg = {shreg[adc_seq_pkg::RESULT_BITS-2:0], 1'b0};
      end
   end

   // falling-edge registers, cleared while chip select is high
   always_ff @(negedge SCLK or negedge lrst_n) begin
      if (!lrst_n) begin
         started   <= 1'b0;
         fall_cnt  <= '0;
         phase     <= IDLE;
         conv_chan <= adc_seq_pkg::CHAN_RESET;
         shreg     <= adc_seq_pkg::SAMPLE_RESET;
         dbit      <= 1'b0;
         oe        <= 1'b0;
      end else begin
         started   <= next_started;
         fall_cnt  <= next_fall_cnt;
         phase     <= next_phase;
         conv_chan <= next_conv_chan;
         shreg     <= next_shreg;
         dbit      <= next_dbit;
         oe        <= next_oe;
      end
   end

   // sample toggle must survive chip select so no event is lost
   always_ff @(negedge SCLK or negedge RESETN) begin
      if (!RESETN) tog <= 1'b0;
      else         tog <= (CS_N) ? tog : next_tog;
   end

   // output stage in link domain, registered on the falling edge
   always_ff @(negedge SCLK or negedge lrst_n) begin
      if (!lrst_n) begin
         DOUT      <= 1'b0;
         DOUT_OE_N <= 1'b1;                   // released
         TRACK     <= 1'b0;
         MUX_SEL   <= adc_seq_pkg::CHAN_RESET;
         POWER_UP  <= 1'b0;
      end else begin
         DOUT      <= next_dbit;
         DOUT_OE_N <= ~next_oe;
         TRACK     <= (next_phase == TRACKING);
         MUX_SEL   <= next_conv_chan;
         // off from the sixteenth fall until the next group tracks
         POWER_UP  <= (next_phase != IDLE) && (next_fall_cnt !=
                      CW'(adc_seq_pkg::CYCLES_PER_CONV-1));
      end
   end

   // sample events reported in the system domain
   adc_sample_sync u_sync (
      .clk          (SYS_CLK),
      .rst_n        (RESETN),
      .lnk          (lnk),
      .sample_pulse (SAMPLE_STROBE),
      .sample_chan  (SAMPLE_CHAN)
   );
endmodule : adc_frame_seq

// ===== bench/adc_frame_seq_sva.sv
`timescale 1ns/1ps
// checks serial timing and sample handoff at the sequencer pins
module adc_frame_seq_sva (
   input wire logic                                  SYS_CLK,
   input wire logic                                  RESETN,
   input wire logic                                  SCLK,
   input wire logic                                  CS_N,
   input wire logic                                  DIN,
   input wire logic [adc_seq_pkg::RESULT_BITS-1:0]   SAMPLE_CODE,
   input wire logic                                  DOUT,
   input wire logic                                  DOUT_OE_N,
   input wire logic                                  TRACK,
   input wire logic [1:0]                            MUX_SEL,
   input wire logic                                  POWER_UP,
   input wire logic                                  SAMPLE_STROBE,
   input wire logic [1:0]                            SAMPLE_CHAN
);
   logic [4:0] fall;       // falls seen in the current group
   logic [4:0] next_fall;  // next value of fall
   wire        off = CS_N || !RESETN;  // link logic idle
   // wrap after the sixteenth fall of a group
   always_comb next_fall = (fall == 5'h10) ? 5'h01 : fall + 5'h01;
   // count falls, cleared whenever the frame is closed
   always_ff @(negedge SCLK or posedge CS_N or negedge RESETN) begin
      if (!RESETN) fall <= 5'h00;
      else if (CS_N) fall <= 5'h00;
      else fall <= next_fall;
   end
   property p_track;
      @(posedge SCLK) disable iff (off) fall != 0 |-> TRACK == (fall < 4);
   endproperty
   a_track: assert property (p_track) else $error("track phase");
   property p_oe;
      @(posedge SCLK) disable iff (off) fall != 0 |-> !DOUT_OE_N;
   endproperty
   a_oe: assert property (p_oe) else $error("output not driven");
   property p_dout;
      @(posedge SCLK) disable iff (off) fall != 0 |-> DOUT == ((fall > 4
         && fall < 15) ? SAMPLE_CODE[5'h0E - fall] : 1'b0);
   endproperty
   a_dout: assert property (p_dout) else $error("serial bit");
   property p_pwr;
      @(posedge SCLK) disable iff (off) fall inside {[1:14]} |-> POWER_UP;
   endproperty
   a_pwr: assert property (p_pwr) else $error("power low");
   property p_gap;
      @(posedge SCLK) disable iff (off) fall == 16 |-> !POWER_UP;
   endproperty
   a_gap: assert property (p_gap) else $error("power between groups");
   property p_release;
      @(posedge SYS_CLK) disable iff (!RESETN) CS_N |-> DOUT_OE_N;
   endproperty
   a_release: assert property (p_release) else $error("not released");
   property p_pdown;
      @(posedge SYS_CLK) disable iff (!RESETN) CS_N |-> !POWER_UP && !TRACK;
   endproperty
   a_pdown: assert property (p_pdown) else $error("not idle");
   property p_strobe;
      @(posedge SYS_CLK) disable iff (!RESETN)
         SAMPLE_STROBE |=> !SAMPLE_STROBE [*8];
   endproperty
   a_strobe: assert property (p_strobe) else $error("strobe width");
   property p_mux;
      @(posedge SYS_CLK) disable iff (!RESETN)
         SAMPLE_STROBE |-> SAMPLE_CHAN == MUX_SEL;
   endproperty
   a_mux: assert property (p_mux) else $error("sample channel");
endmodule : adc_frame_seq_sva
bind adc_frame_seq adc_frame_seq_sva u_adc_frame_seq_sva (.SYS_CLK, .RESETN,
   .SCLK, .CS_N, .DIN, .SAMPLE_CODE, .DOUT, .DOUT_OE_N, .TRACK, .MUX_SEL,
   .POWER_UP, .SAMPLE_STROBE, .SAMPLE_CHAN);

// ===== bench/adc_host.sv
`timescale 1ns/1ps
// serial host: 160 ns clock that stands high outside frames
module adc_host (
   output logic      SCLK,
   output logic      CS_N,
   output logic      DIN,
   input  wire logic DOUT
);
   logic [9:0] rx;  // last result shifted in
   // chip select starts low so the power-on reset gives the link logic
   // a real falling edge on its combined reset
   initial begin
      SCLK = 1'b1;
      CS_N = 1'b0;
      DIN  = 1'b0;
      rx   = 10'h000;
      #10 CS_N = 1'b1;
   end
   // n groups of sixteen clocks, cut short after cut clocks
   task automatic frame(input logic [7:0] ctrl, input int n, input int cut);
      #1.3 CS_N = 1'b0;
      for (int i = 0; i < 16 * n && i < cut; i++) begin
         #40 SCLK = 1'b0;
         DIN = (i % 16 < 8) ? ctrl[7 - i % 16] : ~DIN;
         #80 SCLK = 1'b1;
         if (i % 16 > 3 && i % 16 < 14) rx = {rx[8:0], DOUT};
         #40;
      end
      CS_N = 1'b1;
   endtask : frame
endmodule : adc_host

// ===== bench/test_quad_input_serial_adc_frame_sequencer.sv
`timescale 1ns/1ps
module test_quad_input_serial_adc_frame_sequencer;
   logic       SYS_CLK = 1'b0;      // system clock
   logic       RESETN = 1'b1;       // reset, pulsed low at start
   logic [9:0] SAMPLE_CODE = 10'h000;  // code from converter model
   wire        SCLK, CS_N, DIN, DOUT, DOUT_OE_N, TRACK, POWER_UP;
   wire        SAMPLE_STROBE;
   wire  [1:0] MUX_SEL, SAMPLE_CHAN;
   int         n_fail = 0, checked = 0, n_strobe = 0;
   initial forever #2.5 SYS_CLK = ~SYS_CLK;
   // count sample pulses seen in the system domain
   always @(posedge SYS_CLK) if (SAMPLE_STROBE === 1'b1) n_strobe++;
   adc_frame_seq u_adc_frame_seq (.SYS_CLK, .RESETN, .SCLK, .CS_N, .DIN,
      .SAMPLE_CODE, .DOUT, .DOUT_OE_N, .TRACK, .MUX_SEL, .POWER_UP,
      .SAMPLE_STROBE, .SAMPLE_CHAN);
   // released output shows the inverse of its last bit
   adc_host u_adc_host (.SCLK, .CS_N, .DIN, .DOUT(DOUT_OE_N ? ~DOUT : DOUT));
   task automatic check(input string what, input logic [9:0] seen,
                        input logic [9:0] exp);
      checked++;
      if (seen !== exp) begin
         n_fail++;
         $display("[FAIL] %s expected %h seen %h", what, exp, seen);
      end
   endtask : check
   task automatic results;
      $display("checks %0d mismatches %0d", checked, n_fail);
      if (n_fail == 0 && checked > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
   endtask : results
   // every channel code, ignored bits set, two groups per frame
   task automatic t_channels;
      for (int c = 0; c < 4; c++) begin
         @(negedge SYS_CLK) SAMPLE_CODE = 10'h2A5 ^ 10'(c * 99);
         n_strobe = 0;
         u_adc_host.frame(8'hE7 | 8'(c << 3), 2, 32);
         #200;
         check("result", u_adc_host.rx, SAMPLE_CODE);
         check("strobes", 10'(n_strobe), 10'h002);
         check("chan", {8'h00, SAMPLE_CHAN}, 10'(c));
      end
      $display("t_channels done");
   endtask : t_channels
   // abort mid-frame, full frame after it, then a second reset
   task automatic t_abort;
      u_adc_host.frame(8'h08, 1, 10);
      #20;
      check("oe_n", {9'h000, DOUT_OE_N}, 10'h001);
      check("power", {9'h000, POWER_UP}, 10'h000);
      @(negedge SYS_CLK) SAMPLE_CODE = 10'h3C3;
      n_strobe = 0;
      // leaves input four stored for the next conversion
      u_adc_host.frame(8'h18, 1, 16);
      #200;
      check("result", u_adc_host.rx, 10'h3C3);
      check("strobes", 10'(n_strobe), 10'h001);
      check("chan", {8'h00, SAMPLE_CHAN}, 10'h001);
      @(negedge SYS_CLK) RESETN = 1'b0;
      repeat (3) @(negedge SYS_CLK);
      RESETN = 1'b1;
      check("mux", {8'h00, MUX_SEL}, 10'h000);
      // stored input four must be gone: next sample is input one
      repeat (2) @(negedge SYS_CLK);
      n_strobe = 0;
      u_adc_host.frame(8'h00, 1, 16);
      #200;
      check("result", u_adc_host.rx, 10'h3C3);
      check("strobes", 10'(n_strobe), 10'h001);
      check("chan", {8'h00, SAMPLE_CHAN}, 10'h000);
      $display("t_abort done");
   endtask : t_abort
   initial begin
      // a true falling edge so every asynchronous reset fires
      @(negedge SYS_CLK) RESETN = 1'b0;
      repeat (12) @(negedge SYS_CLK);
      RESETN = 1'b1;
      repeat (4) @(negedge SYS_CLK);
      check("mux", {8'h00, MUX_SEL}, 10'h000);
      t_channels;
      t_abort;
      results;
   end
   // cut a hang short
   initial begin
      #100000;
      n_fail++;
      results;
   end
endmodule : test_quad_input_serial_adc_frame_sequencer
